// ---- logic/rq_pkg.sv ----
// Types shared by the rail enable qualifier.
`default_nettype none
package rq_pkg;

  // Register access request from the serial access port.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rq_reg_req_s;

  // Configuration registers.
  typedef struct packed {
    logic [7:0] mask_primary;
    logic [7:0] source_and_mask;
    logic [7:0] edge_delays;
  } rq_cfg_s;

  // Whole state of the qualifier.
  typedef struct packed {
    rq_cfg_s     cfg;
    logic [17:0] div;
    logic [6:0]  ms;
    logic        dly;
    logic        rail;
    logic [7:0]  rdata;
  } rq_state_s;

endpackage : rq_pkg
`default_nettype wire

// ---- logic/rq_rail_enable_qualifier.sv ----
// Enable qualification of the target step-down rail: source, edge delays, power-good gating.
`timescale 1ns/1ps
`default_nettype none
`include "rq_regs.svh"

// Functional notes
// - Mask 0 includes power good, 1 excludes.
// - Primary mask bits seven..zero map rails.
// - Second register bits 1,0 mask switch rails.
// - Select field 4:2 picks control pin.
// - Code 111 forces enable source high.
// - Code 101 pins three&four, 110 six.
// - Rise delay field 2:0 code table.
// - Fall delay field 5:3 same table.
// - Delays lie within ten percent tolerance.
module rq_rail_enable_qualifier #(
  parameter int unsigned MS_CYCLES = `RQ_MS_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire rq_pkg::rq_reg_req_s reg_req,
  output logic [7:0]               reg_rdata,
  input  wire logic [5:0]          control_pins,
  input  wire logic [9:0]          power_good,
  output logic                     rail_enable
);

  // --------------------------------------------------------------------------
  // Decode functions
  // --------------------------------------------------------------------------

  // Nominal delay in milliseconds for a three-bit edge delay code.
  function automatic logic [6:0] delay_ms(input logic [2:0] code);
    case (code)
      3'h0:    delay_ms = 7'h00;
      3'h1:    delay_ms = 7'h02;
      3'h2:    delay_ms = 7'h04;
      3'h3:    delay_ms = 7'h08;
      3'h4:    delay_ms = 7'h10;
      3'h5:    delay_ms = 7'h18;
      3'h6:    delay_ms = 7'h20;
      default: delay_ms = 7'h40;
    endcase
  endfunction : delay_ms

  // Enable source for a select code; bit n of pins is control pin n+1.
  function automatic logic pick_source(input logic [2:0] sel, input logic [5:0] pins);
    case (sel)
      `RQ_SEL_PIN_ONE:         pick_source = pins[0];
      `RQ_SEL_PIN_TWO:         pick_source = pins[1];
      `RQ_SEL_PIN_FIVE:        pick_source = pins[4];
      `RQ_SEL_PIN_FOUR:        pick_source = pins[3];
      `RQ_SEL_PIN_THREE:       pick_source = pins[2];
      `RQ_SEL_PINS_THREE_FOUR: pick_source = pins[2] & pins[3];
      `RQ_SEL_PIN_SIX:         pick_source = pins[5];
      default:                 pick_source = 1'b1;
    endcase
  endfunction : pick_source

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------

  rq_pkg::rq_state_s st_q;
  rq_pkg::rq_state_s st_d;
  logic [2:0]        sel;
  logic [2:0]        active_code;
  logic [6:0]        target_ms;
  logic [9:0]        mask_all;
  logic              src;
  logic              pg_ok;
  logic              tick;

  // Combinational view of selection, masking and the pending delay target.
  always_comb begin
    sel = st_q.cfg.source_and_mask[`RQ_SRC_SEL_HI:`RQ_SRC_SEL_LO];
    src = pick_source(sel, control_pins);
    // Bits 9..8 are the two switch rails, 7..0 the primary mask rails.
    mask_all = {st_q.cfg.source_and_mask[`RQ_SRC_MASK_HI:`RQ_SRC_MASK_LO],
                st_q.cfg.mask_primary};
    pg_ok = &(power_good | mask_all);
    active_code = src ? st_q.cfg.edge_delays[`RQ_DLY_RISE_HI:`RQ_DLY_RISE_LO]
                      : st_q.cfg.edge_delays[`RQ_DLY_FALL_HI:`RQ_DLY_FALL_LO];
    target_ms = delay_ms(active_code);
    tick = (st_q.div == 18'(MS_CYCLES - 1));
  end

  // Registers, time base and delayed enable; the time base restarts at each new edge.
  always_comb begin
    st_d = st_q;
    if (reg_req.wr) begin
      case (reg_req.addr)
        `RQ_OFS_POWER_GOOD_MASK_PRIMARY: st_d.cfg.mask_primary    = reg_req.wdata;
        `RQ_OFS_SOURCE_AND_MASK:    st_d.cfg.source_and_mask = reg_req.wdata;
        `RQ_OFS_EDGE_DELAYS:        st_d.cfg.edge_delays     = reg_req.wdata;
        default:                    st_d.cfg = st_q.cfg;
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        `RQ_OFS_POWER_GOOD_MASK_PRIMARY: st_d.rdata = st_q.cfg.mask_primary;
        `RQ_OFS_SOURCE_AND_MASK:    st_d.rdata = st_q.cfg.source_and_mask;
        `RQ_OFS_EDGE_DELAYS:        st_d.rdata = st_q.cfg.edge_delays;
        default:                    st_d.rdata = `RQ_RDATA_UNMAPPED;
      endcase
    end
    if (src == st_q.dly) begin
      st_d.div = 18'h0;
      st_d.ms  = 7'h00;
    end else if (target_ms == 7'h00) begin
      st_d.dly = src;
    end else if (tick) begin
      st_d.div = 18'h0;
      st_d.ms  = st_q.ms + 7'h01;
      if (st_q.ms + 7'h01 >= target_ms) begin
        st_d.dly = src;
        st_d.ms  = 7'h00;
      end
    end else begin
      st_d.div = st_q.div + 18'h1;
    end
    st_d.rail = st_q.dly & pg_ok;
  end

  // State register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{cfg: '{mask_primary: `RQ_RST_POWER_GOOD_MASK_PRIMARY,
                       source_and_mask: `RQ_RST_SOURCE_AND_MASK,
                       edge_delays: `RQ_RST_EDGE_DELAYS},
                div: 18'h0, ms: 7'h00, dly: 1'b0, rail: 1'b0, rdata: 8'h00};
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata   = st_q.rdata;
  assign rail_enable = st_q.rail;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------

  // Cycles spent with the source differing from the delayed enable.
  logic [31:0] elapsed_q;
  logic [31:0] nominal;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      elapsed_q <= 32'h0;
    end else if (src != st_q.dly) begin
      elapsed_q <= elapsed_q + 32'h1;
    end else begin
      elapsed_q <= 32'h0;
    end
  end

  // Expected cycles from an edge to the delayed enable following it.
  always_comb begin
    nominal = (target_ms == 7'h00) ? 32'h1 : 32'(target_ms) * 32'(MS_CYCLES);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_src_high_stable;
    src && $stable(st_q.cfg);
  endsequence

  sequence s_edge_done;
    $changed(st_q.dly);
  endsequence

  // Power-good gating: a masked good never blocks, an unmasked low good always does.
  chk_mask_excludes_all: assert property (
    (&mask_all && st_q.dly) |=> rail_enable)
    else $error("Fully masked rail did not enable with delayed source high.");

  chk_primary_bit_seven: assert property (
    (!st_q.cfg.mask_primary[7] && !power_good[7]) |=> !rail_enable)
    else $error("Unmasked bit seven power good low but rail enabled.");

  chk_switch_b_two: assert property (
    (!st_q.cfg.source_and_mask[1] && !power_good[9]) |=> !rail_enable)
    else $error("Unmasked combined switch power good low but rail enabled.");

  // Enable source selection, including the forced and combined codes.
  chk_select_pin_five: assert property (
    (sel == 3'h2) |-> (src == control_pins[4]))
    else $error("Select code 010 did not pick control pin five.");

  chk_forced_source: assert property (
    (sel == 3'h7) |-> src)
    else $error("Select code 111 did not force the source high.");

  chk_combo_source: assert property (
    (sel == 3'h5) |-> (src == (control_pins[2] & control_pins[3])))
    else $error("Select code 101 did not combine pins three and four.");

  // Edge delays measured against the nominal cycle count of the active code.
  chk_rise_delay_time: assert property (
    (s_src_high_stable ##1 ($rose(st_q.dly) && $stable(st_q.cfg)))
      |-> ($past(elapsed_q) + 32'h1 == $past(nominal)))
    else $error("Rising delayed enable arrived at the wrong time.");

  chk_fall_delay_time: assert property (
    ($fell(st_q.dly) && $stable(st_q.cfg))
      |-> ($past(elapsed_q) + 32'h1 == $past(nominal)))
    else $error("Falling delayed enable arrived at the wrong time.");

  chk_delay_tolerance: assert property (
    (s_edge_done ##0 $stable(st_q.cfg))
      |-> ((($past(elapsed_q) + 32'h1) * 32'hA <= $past(nominal) * 32'hB) &&
           (($past(elapsed_q) + 32'h1) * 32'hA >= $past(nominal) * 32'h9)))
    else $error("Edge delay outside ten percent band.");

  chk_code_six_delay: assert property (
    (active_code == 3'h6) |-> (target_ms == 7'h20))
    else $error("Delay code 110 does not give 32 ms.");

  // The rail output only follows a qualified condition one cycle earlier.
  chk_enable_condition: assert property (
    rail_enable |-> $past(st_q.dly && pg_ok))
    else $error("Rail enabled without delayed source and good power.");

endmodule : rq_rail_enable_qualifier
`default_nettype wire

// ---- logic/rq_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the rail enable qualifier.
`ifndef RQ_REGS_SVH
`define RQ_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RQ_OFS_POWER_GOOD_MASK_PRIMARY  8'h0A
`define RQ_OFS_SOURCE_AND_MASK     8'h0E
`define RQ_OFS_EDGE_DELAYS         8'h0F

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RQ_RST_POWER_GOOD_MASK_PRIMARY  8'h00
`define RQ_RST_SOURCE_AND_MASK     8'h00
`define RQ_RST_EDGE_DELAYS         8'h00
`define RQ_RDATA_UNMAPPED          8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RQ_SRC_MASK_HI             1
`define RQ_SRC_MASK_LO             0
`define RQ_SRC_SEL_HI              4
`define RQ_SRC_SEL_LO              2
`define RQ_DLY_RISE_HI             2
`define RQ_DLY_RISE_LO             0
`define RQ_DLY_FALL_HI             5
`define RQ_DLY_FALL_LO             3

// ----------------------------------------------------------------------------
// Enable source codes
// ----------------------------------------------------------------------------
`define RQ_SEL_PIN_ONE             3'h0
`define RQ_SEL_PIN_TWO             3'h1
`define RQ_SEL_PIN_FIVE            3'h2
`define RQ_SEL_PIN_FOUR            3'h3
`define RQ_SEL_PIN_THREE           3'h4
`define RQ_SEL_PINS_THREE_FOUR     3'h5
`define RQ_SEL_PIN_SIX             3'h6
`define RQ_SEL_FORCED_ON           3'h7

// ----------------------------------------------------------------------------
// Timing: clock rate and millisecond time base
// ----------------------------------------------------------------------------
`define RQ_CLK_KHZ                 200000
`define RQ_TIME_BASE_MS            1
`define RQ_MS_CYCLES               (`RQ_CLK_KHZ * `RQ_TIME_BASE_MS)
`define RQ_TOL_PERCENT             10

`endif

// ---- verification/rail_enable_qualifier_test.sv ----
// Self-checking testbench of the rail enable qualifier.
`timescale 1ns/1ps
`default_nettype none
`include "rq_regs.svh"
// ----------------------------------------------------------------------------
// Testbench top
// ----------------------------------------------------------------------------
module rail_enable_qualifier_test;
  localparam int MS = 10;
  logic                ref_clk = 1'b0;
  logic                rst     = 1'b1;
  rq_pkg::rq_reg_req_s req     = '0;
  logic [9:0]          power_good = 10'h000;
  logic [7:0]          reg_rdata;
  logic [5:0]          control_pins;
  logic                rail_enable;
  int                  n_fail  = 0;
  int                  n_tests = 0;
  int                  dms[8]  = '{0, 2, 4, 8, 16, 24, 32, 64};

  // The clock toggles every half period of 2.5 ns.
  always #2.5 ref_clk = ~ref_clk;

  rq_rail_enable_qualifier #(.MS_CYCLES(MS)) u_dut (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .reg_req      (req),
    .reg_rdata    (reg_rdata),
    .control_pins (control_pins),
    .power_good   (power_good),
    .rail_enable  (rail_enable)
  );
  rq_ctl_model u_ctl (.control_pins(control_pins));

  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
    end
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick(1);
    req.wr = 1'b0;
    tick(1);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    req.rd = 1'b1;
    req.addr = a;
    tick(1);
    req.rd = 1'b0;
    check(reg_rdata, e);
    tick(1);
  endtask : rd_chk

  // Rail must hold its old level at 90 percent of n and reach v within a further 110 percent of n plus 3 cycles.
  task automatic edge_chk(input logic v, input int n);
    int i;
    tick(n * 9 / 10);
    check(8'(rail_enable), 8'(!v));
    i = 0;
    while (rail_enable !== v && i < n * 11 / 10 + 3) begin
      tick(1);
      i++;
    end
    check(8'(rail_enable), 8'(v));
  endtask : edge_chk

  task automatic regs_test();
    rd_chk(`RQ_OFS_POWER_GOOD_MASK_PRIMARY, `RQ_RST_POWER_GOOD_MASK_PRIMARY);
    rd_chk(`RQ_OFS_EDGE_DELAYS, `RQ_RST_EDGE_DELAYS);
    wr_reg(`RQ_OFS_POWER_GOOD_MASK_PRIMARY, 8'hA5);
    wr_reg(`RQ_OFS_SOURCE_AND_MASK, 8'hE3);
    wr_reg(`RQ_OFS_EDGE_DELAYS, 8'hC9);
    wr_reg(8'h0B, 8'h5A);
    rd_chk(`RQ_OFS_POWER_GOOD_MASK_PRIMARY, 8'hA5);
    rd_chk(`RQ_OFS_SOURCE_AND_MASK, 8'hE3);
    rd_chk(`RQ_OFS_EDGE_DELAYS, 8'hC9);
    rd_chk(8'h0B, `RQ_RDATA_UNMAPPED);
  endtask : regs_test

  // Every select code against every pin pattern, with all power goods masked.
  task automatic source_test();
    logic e;
    wr_reg(`RQ_OFS_POWER_GOOD_MASK_PRIMARY, 8'hFF);
    wr_reg(`RQ_OFS_EDGE_DELAYS, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr_reg(`RQ_OFS_SOURCE_AND_MASK, {3'h0, 3'(c), 2'h3});
      for (int p = 0; p < 64; p++) begin
        u_ctl.set_pins(6'(p));
        tick(3);
        case (c)
          0: e = p[0];
          1: e = p[1];
          2: e = p[4];
          3: e = p[3];
          4: e = p[2];
          5: e = p[2] & p[3];
          6: e = p[5];
          default: e = 1'b1;
        endcase
        check(8'(rail_enable), 8'(e));
      end
    end
    u_ctl.set_pins(6'h00);
  endtask : source_test

  // Each power good alone unmasked: it alone decides the rail.
  task automatic good_test();
    logic [9:0] m;
    for (int i = 0; i < 10; i++) begin
      m = ~(10'h001 << i);
      wr_reg(`RQ_OFS_POWER_GOOD_MASK_PRIMARY, m[7:0]);
      wr_reg(`RQ_OFS_SOURCE_AND_MASK, {3'h0, 3'h7, m[9:8]});
      power_good = m;
      tick(3);
      check(8'(rail_enable), 8'h00);
      power_good = ~m;
      tick(3);
      check(8'(rail_enable), 8'h01);
    end
  endtask : good_test

  task automatic delay_test();
    wr_reg(`RQ_OFS_SOURCE_AND_MASK, 8'h03);
    wr_reg(`RQ_OFS_POWER_GOOD_MASK_PRIMARY, 8'hFF);
    for (int k = 0; k < 8; k++) begin
      wr_reg(`RQ_OFS_EDGE_DELAYS, {2'h0, 3'(k), 3'(k)});
      tick(3);
      u_ctl.set_pins(6'h01);
      edge_chk(1'b1, dms[k] * MS);
      u_ctl.set_pins(6'h00);
      edge_chk(1'b0, dms[k] * MS);
    end
  endtask : delay_test

  // Main sequence: reset for 16 cycles, then every scenario in turn.
  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check(8'(rail_enable), 8'h00);
    regs_test();
    source_test();
    good_test();
    delay_test();
    wrap_up();
  end

  // Watchdog cuts a hang well beyond the expected run length.
  initial begin
    tick(30000);
    n_fail++;
    wrap_up();
  end
endmodule : rail_enable_qualifier_test
`default_nettype wire

// ---- verification/rq_ctl_model.sv ----
// System controller model that drives the six enable control pins.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Control pin driver
// ----------------------------------------------------------------------------
module rq_ctl_model (
  output var logic [5:0] control_pins
);
  // The pins start low so the rail sees no enable request out of reset.
  initial begin
    control_pins = 6'h00;
  end

  // Drives a new pin pattern; callers change it just after a clock edge.
  task automatic set_pins(input logic [5:0] v);
    control_pins = v;
  endtask : set_pins
endmodule : rq_ctl_model
`default_nettype wire
